// ### testbench/isw_asserts.sv
// Purpose: port checks for the bus switch control logic
// Assumes: one clock domain, i_sys_rst synchronous
// Notes:   pin reset tracked by a short level history
`timescale 1ns/100ps
module isw_checker
(
    input wire logic       i_core_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_rst_n,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda,
    input wire logic       o_sda_oe_n,
    input wire logic       i_addr_strap_low,
    input wire logic       i_addr_strap_high,
    input wire logic [3:0] i_channel_irq_inputs_n,
    input wire logic       o_irq_n,
    input wire logic       o_irq_oe_n,
    input wire logic [3:0] o_downstream_pair_enable
);
    // ====================
    // Last five pin reset levels; the pin acts through a synchroniser
    logic [4:0] rn_r;
    logic [4:0] rn_nxt;
    logic       rn_ok;
    always_comb rn_nxt = {rn_r[3:0], i_rst_n};
    always_ff @(posedge i_core_clk) rn_r <= rn_nxt;
    assign rn_ok = (rn_r == 5'h1f);

    // ====================
    // Properties
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    chk_reset_outputs: assert property (disable iff (1'b0)
        i_sys_rst |=> o_downstream_pair_enable == 4'h0 && o_sda_oe_n && o_irq_oe_n)
        else $error("outputs not cleared in reset");
    chk_pin_reset: assert property ((!i_rst_n)[*4] |=>
        o_downstream_pair_enable == 4'h0 && o_sda_oe_n) else $error("pin reset ignored");
    chk_irq_assert: assert property ((i_channel_irq_inputs_n != 4'hf && rn_ok)[*4]
        |-> !o_irq_oe_n) else $error("combined irq not low");
    chk_irq_release: assert property ((i_channel_irq_inputs_n == 4'hf)[*4]
        |-> o_irq_oe_n) else $error("combined irq not released");
    chk_en_at_stop: assert property ($changed(o_downstream_pair_enable) |->
        (i_scl && i_sda && $past(i_scl, 3)) || !rn_ok) else $error("enables moved off stop");
    chk_sda_scl_low: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
        else $error("data drive changed with clock high");
    chk_drive_low: assert property (!o_sda && !o_irq_n)
        else $error("open drain value not low");
    chk_bit_stands: assert property ($fell(o_sda_oe_n) |-> (!o_sda_oe_n)[*6])
        else $error("driven bit too short");

    // Main scenarios reached
    cover property ($changed(o_downstream_pair_enable));
    cover property ($fell(o_irq_oe_n));
    cover property ($fell(o_sda_oe_n));
endmodule

bind isw_top isw_checker u_chk
(
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_rst_n(i_rst_n),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
    .i_addr_strap_low(i_addr_strap_low), .i_addr_strap_high(i_addr_strap_high),
    .i_channel_irq_inputs_n(i_channel_irq_inputs_n), .o_irq_n(o_irq_n),
    .o_irq_oe_n(o_irq_oe_n), .o_downstream_pair_enable(o_downstream_pair_enable)
);

// ### testbench/isw_master.sv
// Purpose: upstream serial controller model
// Assumes: 8 core cycles a bit, lines pulled up when released
// Notes:   clock stands high between frames
`timescale 1ns/100ps
module isw_master
(
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // ====================
    // Idle bus is high on both lines
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Start or repeated start; the address byte follows at once
    task automatic start();
        o_sda = 1'b1;
        hold(2);
        o_scl = 1'b1;
        hold(2);
        o_sda = 1'b0;
        hold(2);
        o_scl = 1'b0;
        hold(2);
    endtask

    // Stop straight after the acknowledge bit
    task automatic stop();
        o_sda = 1'b0;
        hold(2);
        o_scl = 1'b1;
        hold(2);
        o_sda = 1'b1;
        hold(4);
    endtask

    // Eight bits MSB first, ninth bit sent as ack_n, wire sampled mid-high
    task automatic xfer(input logic [7:0] d, input logic ack_n,
                        output logic [7:0] q, output logic acked);
        logic [8:0] tx;
        tx = {d, ack_n};
        for (int i = 8; i >= 0; i--)
        begin
            o_sda = tx[i];
            hold(2);
            o_scl = 1'b1;
            hold(2);
            if (i > 0)
                q[i - 1] = i_sda;
            acked = !i_sda;
            hold(2);
            o_scl = 1'b0;
            hold(2);
        end
    endtask
endmodule

// ### testbench/isw_top_tb.sv
// Purpose: self-checking bench for the bus switch control logic
// Assumes: address is the fixed bits then both straps
// Notes:   stimulus moves on the falling clock edge
`timescale 1ns/100ps
`include "isw_cfg.svh"
module isw_top_tb;
    logic       clk;
    logic       sys_rst;
    logic       rst_n;
    logic       scl;
    logic       m_sda;
    logic       sda;
    logic       sda_oe_n;
    logic       sda_o;
    logic [1:0] strap;
    logic [3:0] irq_n;
    logic       irq_oe_n;
    logic [3:0] pair_en;
    logic [6:0] addr;
    logic [7:0] rd;
    logic       ack;
    int         failures;
    int         comparisons;

    // Wired-and data line with pull-up
    assign sda = m_sda & (sda_oe_n | sda_o);
    assign addr = {`ISW_ADDR_FIXED, strap[1], strap[0]};

    isw_top DUT
    (
        .i_core_clk(clk), .i_sys_rst(sys_rst), .i_rst_n(rst_n), .i_scl(scl),
        .i_sda(sda), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n),
        .i_addr_strap_low(strap[0]), .i_addr_strap_high(strap[1]),
        .i_channel_irq_inputs_n(irq_n), .o_irq_n(), .o_irq_oe_n(irq_oe_n),
        .o_downstream_pair_enable(pair_en)
    );

    isw_master u_master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ====================
    // Register access: write sends two bytes, the second must stick
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1,
                          input logic p, input logic exp_ack);
        u_master.start();
        u_master.xfer({a, 1'b0}, 1'b1, rd, ack);
        u_master.xfer(d0, 1'b1, rd, ack);
        u_master.xfer(d1, 1'b1, rd, ack);
        check("write ack", {7'h0, ack}, {7'h0, exp_ack});
        if (p)
            u_master.stop();
        repeat (8) @(negedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] exp);
        u_master.start();
        u_master.xfer({addr, 1'b1}, 1'b1, rd, ack);
        u_master.xfer(8'hff, 1'b1, rd, ack);
        u_master.stop();
        check("register read", rd, exp);
    endtask

    // ====================
    // Main sequence
    initial
    begin
        failures = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        rst_n = 1'b1;
        strap = 2'b01;
        irq_n = 4'hf;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        check("enables after reset", {4'h0, pair_en}, 8'h00);
        reg_rd(8'h00);
        for (int v = 0; v < 16; v++)
        begin
            reg_wr(addr, 8'h0f ^ 8'(v), {4'(~v), 4'(v)}, 1'b1, 1'b1);
            check("applied enables", {4'h0, pair_en}, 8'(v));
            reg_rd(8'(v));
        end
        reg_wr(addr, 8'h00, 8'h05, 1'b0, 1'b1);
        check("pending enables", {4'h0, pair_en}, 8'h0f);
        u_master.stop();
        repeat (8) @(negedge clk);
        check("enables at stop", {4'h0, pair_en}, 8'h05);
        reg_wr({`ISW_ADDR_FIXED, 2'b10}, 8'h00, 8'h0a, 1'b1, 1'b0);
        check("unaddressed write ignored", {4'h0, pair_en}, 8'h05);
        strap = 2'b10;
        repeat (8) @(negedge clk);
        reg_wr(addr, 8'h00, 8'h0a, 1'b1, 1'b1);
        check("strapped write", {4'h0, pair_en}, 8'h0a);
        // Repeated start into a two-byte read; stored enables show before stop
        reg_wr(addr, 8'h00, 8'h06, 1'b0, 1'b1);
        u_master.start();
        u_master.xfer({addr, 1'b1}, 1'b1, rd, ack);
        u_master.xfer(8'hff, 1'b0, rd, ack);
        check("first read byte", rd, 8'h06);
        u_master.xfer(8'hff, 1'b1, rd, ack);
        check("second read byte", rd, 8'h06);
        check("enables before stop", {4'h0, pair_en}, 8'h0a);
        u_master.stop();
        repeat (8) @(negedge clk);
        check("enables after restart", {4'h0, pair_en}, 8'h06);
        for (int c = 0; c < 5; c++)
        begin
            irq_n = (c < 4) ? ~(4'h1 << c) : 4'h6;
            repeat (4) @(negedge clk);
            check("combined irq", {7'h0, irq_oe_n}, 8'h00);
            reg_rd({~irq_n, 4'h6});
        end
        irq_n = 4'hf;
        repeat (4) @(negedge clk);
        check("irq released", {7'h0, irq_oe_n}, 8'h01);
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        check("enables after second reset", {4'h0, pair_en}, 8'h00);
        reg_wr(addr, 8'h00, 8'h0c, 1'b1, 1'b1);
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        check("enables after pin reset", {4'h0, pair_en}, 8'h00);
        reg_rd(8'h00);
        wrap_up();
    end

    // Hang guard, well beyond the expected run
    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        wrap_up();
    end
endmodule

// ### verilog/isw_cfg.svh
// Purpose: constants of the four-channel bus switch control logic
// Assumes: included by bare name; definitions only
// Notes:   positions, reset values and counts live here, types in isw_pkg
//
// Behaviour
// - Direction 1 reads, 0 writes the register
// - First byte after address ack is stored
// - Several bytes written: only last one kept
// - Read returns the register contents
// - Low four bits enable channels independently
// - Any channel combination, all or none, allowed
// - New selection applied only at stop
// - Reset clears register, no channel connected
// - Combined interrupt low when any input low
// - Interrupts reported whether channel connected or not
// - Bits 4 to 7 map channels 0 to 3
// - Interrupt levels sampled when read happens
// - Status bit 1 means pending interrupt
// - Interrupt inputs usable as plain readable inputs
// - Address is fixed bits plus two straps
// - Reset pin low restores defaults, disconnects channels
// - Power-on reset clears everything to zero; synchronisers and line history load ones here
`ifndef ISW_CFG_SVH
`define ISW_CFG_SVH

// ====================================================================
// Target address
`define ISW_ADDR_FIXED       5'h15
`define ISW_RW_READ          1'b1

// ====================================================================
// Register layout and reset values
`define ISW_CHAN0_ENABLE_BIT 0
`define ISW_CHAN1_ENABLE_BIT 1
`define ISW_CHAN2_ENABLE_BIT 2
`define ISW_CHAN3_ENABLE_BIT 3
`define ISW_IRQ_STATUS_LSB   4
`define ISW_IRQ_STATUS_MSB   7
`define ISW_CHAN_RST         4'h0
`define ISW_BYTE_RST         8'h00

// ====================================================================
// Serial framing
`define ISW_BITS_PER_BYTE    4'h8
`define ISW_CNT_RST          4'h0
`define ISW_SYNC_RST         9'h1ff

`endif

// ### verilog/isw_pkg.sv
// Purpose: types shared by the bus switch control logic
// Assumes: nothing beyond the standard language
// Notes:   constants are macros in isw_cfg.svh
package isw_pkg;

    // ================================================================
    // Serial target states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK
    } isw_state_t;

endpackage

// ### verilog/isw_top.sv
// Purpose: control logic of a four-channel bus switch, serial target
// Assumes: serial clock much slower than i_core_clk (8 or more cycles)
// Notes:   no clock stretching; data line is open drain, active low enable
`timescale 1ns/100ps
`include "isw_cfg.svh"

module isw_top
    import isw_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    input  wire logic       i_addr_strap_low,
    input  wire logic       i_addr_strap_high,
    input  wire logic [3:0] i_channel_irq_inputs_n,
    output logic            o_irq_n,
    output logic            o_irq_oe_n,
    output logic [3:0]      o_downstream_pair_enable
);

    // ================================================================
    // Declarations
    logic [8:0]  sync_s1_r;
    logic [8:0]  sync_s2_r;
    logic        scl_d_r;
    logic        sda_d_r;
    logic        scl_s;
    logic        sda_s;
    logic        rst_pin_n_s;
    logic [1:0]  strap_s;
    logic [3:0]  irq_n_s;
    logic        rst;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_seen;
    logic        stop_seen;
    logic        addr_hit;
    logic [7:0]  chan_sel_irq_status;

    isw_state_t  state_r;
    isw_state_t  state_nxt;
    logic [7:0]  shift_r;
    logic [7:0]  shift_nxt;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;
    logic        ack_ok_r;
    logic        ack_ok_nxt;
    logic [3:0]  sel_r;
    logic [3:0]  sel_nxt;
    logic        pend_r;
    logic        pend_nxt;
    logic [3:0]  chan_r;
    logic [3:0]  chan_nxt;
    logic        drive_r;
    logic        drive_nxt;
    logic        irq_low_r;
    logic        irq_low_nxt;

    // ================================================================
    // Pin synchronisers
    // Stage one is read only by stage two; reset pin must not reset them
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            sync_s1_r <= `ISW_SYNC_RST;
            sync_s2_r <= `ISW_SYNC_RST;
        end
        else
        begin
            sync_s1_r <= {i_rst_n, i_addr_strap_high, i_addr_strap_low,
                          i_channel_irq_inputs_n, i_scl, i_sda};
            sync_s2_r <= sync_s1_r;
        end
    end

    // Unpack synchronised levels
    assign sda_s       = sync_s2_r[0];
    assign scl_s       = sync_s2_r[1];
    assign irq_n_s     = sync_s2_r[5:2];
    assign strap_s     = sync_s2_r[7:6];
    assign rst_pin_n_s = sync_s2_r[8];

    // Either reset source clears the target and interrupt registers; line history resets high
    assign rst = i_sys_rst | ~rst_pin_n_s;

    // ================================================================
    // Line edge and condition detection
    always_ff @(posedge i_core_clk)
    begin
        if (rst)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Start and stop only while the clock line stays high
    assign scl_rise   = scl_s & ~scl_d_r;
    assign scl_fall   = ~scl_s & scl_d_r;
    assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_seen  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Address compare: fixed part plus two straps
    assign addr_hit = (shift_r[7:1] == {`ISW_ADDR_FIXED, strap_s});

    // Read byte: live interrupt levels above stored enables
    // Inverted so that 1 means pending, whether channel is on or not
    assign chan_sel_irq_status = {~irq_n_s, sel_r};

    // ================================================================
    // Serial target next-state logic
    always_comb
    begin
        state_nxt  = state_r;
        shift_nxt  = shift_r;
        cnt_nxt    = cnt_r;
        ack_ok_nxt = ack_ok_r;
        sel_nxt    = sel_r;
        pend_nxt   = pend_r;
        chan_nxt   = chan_r;
        if (start_seen)
        begin
            // Repeated start also restarts address reception
            state_nxt = ST_ADDR;
            cnt_nxt   = `ISW_CNT_RST;
        end
        else if (stop_seen)
        begin
            state_nxt = ST_IDLE;
            if (pend_r)
            begin
                chan_nxt = sel_r;
                pend_nxt = 1'b0;
            end
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    state_nxt = ST_IDLE;
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt   = cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == `ISW_BITS_PER_BYTE)
                    begin
                        cnt_nxt   = `ISW_CNT_RST;
                        state_nxt = addr_hit ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = `ISW_CNT_RST;
                        if (shift_r[0] == `ISW_RW_READ)
                        begin
                            // Status sampled at the start of the read
                            shift_nxt = chan_sel_irq_status;
                            state_nxt = ST_RD_DATA;
                        end
                        else
                        begin
                            state_nxt = ST_WR_DATA;
                        end
                    end
                end
                ST_WR_DATA:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt   = cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == `ISW_BITS_PER_BYTE)
                    begin
                        // Each byte overwrites; the last one wins
                        sel_nxt   = shift_r[`ISW_CHAN3_ENABLE_BIT:
                                            `ISW_CHAN0_ENABLE_BIT];
                        pend_nxt  = 1'b1;
                        cnt_nxt   = `ISW_CNT_RST;
                        state_nxt = ST_WR_ACK;
                    end
                end
                ST_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_nxt = ST_WR_DATA;
                    end
                end
                ST_RD_DATA:
                begin
                    if (scl_rise)
                    begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt_r == `ISW_BITS_PER_BYTE)
                        begin
                            cnt_nxt   = `ISW_CNT_RST;
                            state_nxt = ST_RD_ACK;
                        end
                        else
                        begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                        end
                    end
                end
                ST_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        ack_ok_nxt = ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        if (ack_ok_r)
                        begin
                            // Controller wants more: fresh sample each byte
                            shift_nxt = chan_sel_irq_status;
                            state_nxt = ST_RD_DATA;
                        end
                        else
                        begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Data line drive follows the next state so it lands one cycle after scl falls
    always_comb
    begin
        drive_nxt = (state_nxt == ST_ADDR_ACK) ||
                    (state_nxt == ST_WR_ACK) ||
                    ((state_nxt == ST_RD_DATA) && !shift_nxt[7]);
    end

    // ================================================================
    // Serial target registers
    always_ff @(posedge i_core_clk)
    begin
        if (rst)
        begin
            state_r  <= ST_IDLE;
            shift_r  <= `ISW_BYTE_RST;
            cnt_r    <= `ISW_CNT_RST;
            ack_ok_r <= 1'b0;
            sel_r    <= `ISW_CHAN_RST;
            pend_r   <= 1'b0;
            chan_r   <= `ISW_CHAN_RST;
            drive_r  <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            shift_r  <= shift_nxt;
            cnt_r    <= cnt_nxt;
            ack_ok_r <= ack_ok_nxt;
            sel_r    <= sel_nxt;
            pend_r   <= pend_nxt;
            chan_r   <= chan_nxt;
            drive_r  <= drive_nxt;
        end
    end

    // ================================================================
    // Combined interrupt output
    // One register stage after the synchroniser; costs three cycles of delay
    always_comb
    begin
        irq_low_nxt = ~&irq_n_s;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (rst)
        begin
            irq_low_r <= 1'b0;
        end
        else
        begin
            irq_low_r <= irq_low_nxt;
        end
    end

    // ================================================================
    // Enables and pair outputs from flip-flops, data values tied low; open-drain pins only ever pull low
    assign o_sda                    = 1'b0;
    assign o_sda_oe_n               = ~drive_r;
    assign o_irq_n                  = 1'b0;
    assign o_irq_oe_n               = ~irq_low_r;
    assign o_downstream_pair_enable = chan_r;

endmodule
